/* inc/range_port_pkg.sv */
// constants, field layouts and types shared by the remote range control port
package range_port_pkg;

	// pin levels after synchronisation, packed into one vector
	localparam int NUM_RANGES  = 7;
	localparam int PIN_RANGE0  = 0;
	localparam int PIN_LOCKOUT = 7;
	localparam int PIN_LOG     = 8;
	localparam int PIN_AUTO    = 9;
	localparam int PIN_FREEZE  = 10;
	localparam int PIN_TRIG    = 11;
	localparam int SYNC_W      = 12;

	// range code: 0 is the 10 nW range, 6 is the 10 mW range
	localparam int              RANGE_W   = 3;
	localparam logic [RANGE_W-1:0] MIN_RANGE = 3'h0;
	localparam logic [RANGE_W-1:0] MAX_RANGE = 3'h6;

	localparam int MEAS_W = 16;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 4;

	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_ADDR    = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_ADDR  = 4'h4;
	localparam logic [ADDR_W-1:0] DISPLAY_ADDR = 4'h8;
	localparam logic [ADDR_W-1:0] COUNT_ADDR   = 4'hc;

	// control fields: the front panel selection
	localparam int CTRL_RANGE_LSB = 0;
	localparam int CTRL_LOG_BIT   = 4;
	localparam int CTRL_AUTO_BIT  = 5;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

	// status fields
	localparam int ST_RANGE_LSB = 0;
	localparam int ST_LOG_BIT   = 4;
	localparam int ST_AUTO_BIT  = 5;
	localparam int ST_LOCK_BIT  = 6;
	localparam int ST_FRZ_BIT   = 7;
	localparam int ST_BUSY_BIT  = 8;
	localparam int ST_DONE_BIT  = 9;
	localparam int ST_OVER_BIT  = 10;
	localparam int ST_UNDER_BIT = 11;

	localparam int COUNT_W = 16;

	// encode cycle length
	localparam int CLK_MHZ        = 40;
	localparam int ENCODE_TIME_NS = 100000;
	localparam int ENCODE_CYCLES  = (ENCODE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int TIMER_W        = 12;
	localparam logic [TIMER_W-1:0] ENCODE_LOAD = TIMER_W'(ENCODE_CYCLES - 1);

	typedef enum logic [1:0]
	{
		ENC_IDLE = 2'b01,
		ENC_CONV = 2'b10
	} encode_state_t;

endpackage : range_port_pkg

/* design/pin_sync.sv */
// three-stage synchroniser with agreement filter for the programming pins
`timescale 1ns/100ps
module pin_sync
(
	input  wire logic                        sys_clk, // system clock
	input  wire logic                        rst,     // async reset
	input  wire logic [range_port_pkg::SYNC_W-1:0] pinN,    // raw pin levels
	output logic      [range_port_pkg::SYNC_W-1:0] levelN   // filtered levels
);
	import range_port_pkg::*;

	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++)
		begin : g_bit
			logic s1Q;
			logic s2Q;
			logic s3Q;
			// all stages reset to 1 so an undriven pin reads inactive
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
				begin
					s1Q <= 1'b1;
					s2Q <= 1'b1;
					s3Q <= 1'b1;
				end
				else
				begin
					s1Q <= pinN[g];
					s2Q <= s1Q;
					s3Q <= s2Q;
				end
			end
			// a change counts only once two later stages agree
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
					levelN[g] <= 1'b1;
				else if (s2Q == s3Q)
					levelN[g] <= s2Q;
			end
		end
	endgenerate

	a_pullup_idle: assert property (@(posedge sys_clk) disable iff (rst)
		$past(rst) |-> (&levelN))
		else $error("pin levels not inactive after reset");

endmodule : pin_sync

/* design/encode_timer.sv */
// fixed-length encode cycle timer
`timescale 1ns/100ps
module encode_timer
(
	input  wire logic sys_clk, // system clock
	input  wire logic rst,     // async reset
	input  wire logic start,   // one-cycle start pulse
	output logic      running, // cycle in progress
	output logic      expire   // one-cycle end pulse
);
	import range_port_pkg::*;

	logic [TIMER_W-1:0] countQ;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			countQ  <= '0;
			running <= 1'b0;
			expire  <= 1'b0;
		end
		else
		begin
			expire <= 1'b0;
			if (start)
			begin
				countQ  <= ENCODE_LOAD;
				running <= 1'b1;
			end
			else if (running)
			begin
				if (countQ == '0)
				begin
					running <= 1'b0;
					expire  <= 1'b1;
				end
				else
					countQ <= countQ - 1'b1;
			end
		end
	end

endmodule : encode_timer

/* design/remote_range_control_port.sv */
// remote programming port: range, mode, freeze and encode trigger control
`timescale 1ns/100ps
module remote_range_control_port
(
	input  wire logic                   sys_clk,             // 40 MHz clock
	input  wire logic                   rst,                 // async reset
	// avalon-mm slave
	input  wire logic [range_port_pkg::ADDR_W-1:0] address,  // byte address
	input  wire logic                   read,                // read request
	input  wire logic                   write,               // write request
	input  wire logic [range_port_pkg::DATA_W-1:0] writedata, // write data
	output logic      [range_port_pkg::DATA_W-1:0] readdata,  // read data
	output logic                        waitrequest,         // stall
	// programming pins, active low
	input  wire logic                   frontPanelLockoutN,  // lockout
	input  wire logic                   logDisplaySelectN,   // log display
	input  wire logic                   autorangeSelectN,    // autorange
	input  wire logic [range_port_pkg::NUM_RANGES-1:0] rangeSelectN, // ranges
	input  wire logic                   displayFreezeN,      // hold display
	input  wire logic                   conversionTriggerN,  // encode trigger
	// measurement side
	input  wire logic [range_port_pkg::MEAS_W-1:0] measIn,   // result
	input  wire logic                   overrangeIn,         // range too low
	input  wire logic                   underrangeIn,        // range too high
	output logic                        convertStart,        // start pulse
	output logic      [range_port_pkg::RANGE_W-1:0] rangeCode, // active range
	output logic                        logMode,             // log display
	output logic                        autoMode,            // autoranging
	output logic      [range_port_pkg::MEAS_W-1:0] displayValue, // reading
	output logic                        conversionDone       // data readable
);
	import range_port_pkg::*;

	// lowest asserted range wins; several pins at once is a controller fault
	function automatic logic [RANGE_W-1:0] lowestRange
	(
		input logic [NUM_RANGES-1:0] sel
	);
		logic [RANGE_W-1:0] idx;
		idx = MIN_RANGE;
		for (int i = NUM_RANGES - 1; i >= 0; i--)
		begin
			if (sel[i])
				idx = RANGE_W'(i);
		end
		return idx;
	endfunction : lowestRange

	logic [SYNC_W-1:0]     levelN;
	logic                  timerRunning;
	logic                  timerExpire;
	logic                  lockout;
	logic                  logPin;
	logic                  autoPin;
	logic                  frozen;
	logic [NUM_RANGES-1:0] rangePins;
	logic                  anyRangePin;
	logic                  trigFall;
	logic                  trigPrevQ;
	encode_state_t         stateQ;
	logic [DATA_W-1:0]     ctrlQ;
	logic [RANGE_W-1:0]    panelRange;
	logic [COUNT_W-1:0]    countQ;
	logic                  overQ;
	logic                  underQ;
	logic                  busAck;
	logic [DATA_W-1:0]     readMux;

	pin_sync u_sync
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.pinN    ({conversionTriggerN, displayFreezeN, autorangeSelectN,
			logDisplaySelectN, frontPanelLockoutN, rangeSelectN}),
		.levelN  (levelN)
	);

	encode_timer u_timer
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.start   (convertStart),
		.running (timerRunning),
		.expire  (timerExpire)
	);

	assign lockout     = !levelN[PIN_LOCKOUT];
	assign logPin      = !levelN[PIN_LOG];
	assign autoPin     = !levelN[PIN_AUTO];
	assign frozen      = !levelN[PIN_FREEZE];
	assign rangePins   = ~levelN[PIN_RANGE0 +: NUM_RANGES];
	assign anyRangePin = |rangePins;
	assign trigFall    = trigPrevQ && levelN[PIN_TRIG] == 1'b0;

	// panel range codes above the top range are clamped to it
	assign panelRange = (ctrlQ[CTRL_RANGE_LSB +: RANGE_W] > MAX_RANGE) ?
		MAX_RANGE : ctrlQ[CTRL_RANGE_LSB +: RANGE_W];

	// ---------------- mode selection ----------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			logMode  <= 1'b0;
			autoMode <= 1'b0;
		end
		else if (lockout)
		begin
			logMode  <= logPin;
			autoMode <= autoPin;
		end
		else
		begin
			logMode  <= ctrlQ[CTRL_LOG_BIT];
			autoMode <= ctrlQ[CTRL_AUTO_BIT];
		end
	end

	// ---------------- range selection ----------------
	// autoranging steps one range per finished encode cycle
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rangeCode <= MIN_RANGE;
		else if (autoMode && timerExpire)
		begin
			if (overrangeIn && rangeCode < MAX_RANGE)
				rangeCode <= rangeCode + 3'h1;
			else if (underrangeIn && rangeCode > MIN_RANGE)
				rangeCode <= rangeCode - 3'h1;
		end
		else if (lockout)
		begin
			// panel selection is ignored; pins steer only without autorange
			if (!autoPin && anyRangePin)
				rangeCode <= lowestRange(rangePins);
		end
		else if (!ctrlQ[CTRL_AUTO_BIT])
			rangeCode <= panelRange;
	end

	// ---------------- encode sequencing ----------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			trigPrevQ <= 1'b1;
		else
			trigPrevQ <= levelN[PIN_TRIG];
	end

	// a trigger edge during a running cycle is ignored
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			stateQ         <= ENC_IDLE;
			convertStart   <= 1'b0;
			conversionDone <= 1'b0;
		end
		else
		begin
			convertStart <= 1'b0;
			case (stateQ)
				ENC_IDLE:
				begin
					if (trigFall)
					begin
						stateQ         <= ENC_CONV;
						convertStart   <= 1'b1;
						conversionDone <= 1'b0;
					end
				end
				ENC_CONV:
				begin
					if (timerExpire)
					begin
						stateQ         <= ENC_IDLE;
						conversionDone <= 1'b1;
					end
				end
				default:
					stateQ <= ENC_IDLE;
			endcase
		end
	end

	// result capture; freeze keeps the old reading on screen
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			displayValue <= '0;
		else if (timerExpire && !frozen)
			displayValue <= measIn;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			overQ  <= 1'b0;
			underQ <= 1'b0;
			countQ <= '0;
		end
		else if (timerExpire)
		begin
			overQ  <= overrangeIn;
			underQ <= underrangeIn;
			countQ <= countQ + 16'h0001;
		end
	end

	// ---------------- avalon-mm slave ----------------
	// one wait cycle per access; waitrequest idles high
	assign busAck = (read || write) && !waitrequest;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			waitrequest <= 1'b1;
		else
			waitrequest <= !((read || write) && waitrequest);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			ctrlQ <= CTRL_RESET;
		else if (write && busAck && address == CTRL_ADDR)
			ctrlQ <= writedata;
	end

	always_comb
	begin
		readMux = '0;
		case (address)
			CTRL_ADDR:
				readMux = ctrlQ & 32'h0000_0037;
			STATUS_ADDR:
			begin
				readMux[ST_RANGE_LSB +: RANGE_W] = rangeCode;
				readMux[ST_LOG_BIT]   = logMode;
				readMux[ST_AUTO_BIT]  = autoMode;
				readMux[ST_LOCK_BIT]  = lockout;
				readMux[ST_FRZ_BIT]   = frozen;
				readMux[ST_BUSY_BIT]  = timerRunning;
				readMux[ST_DONE_BIT]  = conversionDone;
				readMux[ST_OVER_BIT]  = overQ;
				readMux[ST_UNDER_BIT] = underQ;
			end
			DISPLAY_ADDR:
				readMux[MEAS_W-1:0] = displayValue;
			COUNT_ADDR:
				readMux[COUNT_W-1:0] = countQ;
			default:
				readMux = '0;
		endcase
	end

	// read data loads as waitrequest drops and stands while it is low
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			readdata <= '0;
		else if (read && waitrequest)
			readdata <= readMux;
	end

	// ---------------- checks ----------------
	localparam int HCNT_W = 13;
	// the start pulse reaches the timer one edge late, and done is one edge
	// behind the expiry pulse, hence two cycles beyond the encode count
	localparam logic [HCNT_W-1:0] DONE_AT = HCNT_W'(ENCODE_CYCLES + 2);
	logic [HCNT_W-1:0] sinceStartQ;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			sinceStartQ <= '0;
		else if (convertStart)
			sinceStartQ <= 13'h0001;
		else if (sinceStartQ != '1)
			sinceStartQ <= sinceStartQ + 13'h0001;
	end

	sequence s_encode_start;
		convertStart && !conversionDone;
	endsequence

	sequence s_encode_busy;
		(stateQ == ENC_CONV) && !conversionDone;
	endsequence

	a_lockout_holds: assert property (@(posedge sys_clk) disable iff (rst)
		(lockout && !autoMode && !anyRangePin && !timerExpire)
			|=> $stable(rangeCode))
		else $error("range changed under lockout without pin");

	a_log_pin_gate: assert property (@(posedge sys_clk) disable iff (rst)
		!lockout |=> (logMode == $past(ctrlQ[CTRL_LOG_BIT])))
		else $error("log display followed pin without lockout");

	a_auto_pin_gate: assert property (@(posedge sys_clk) disable iff (rst)
		(lockout && autoPin) |=> autoMode)
		else $error("autorange pin under lockout not applied");

	a_range_pin_set: assert property (@(posedge sys_clk) disable iff (rst)
		(lockout && !autoPin && anyRangePin && !(autoMode && timerExpire))
			|=> (rangeCode == lowestRange($past(rangePins))))
		else $error("range pin not applied");

	a_range_auto_blk: assert property (@(posedge sys_clk) disable iff (rst)
		(lockout && autoPin && !autoMode && !timerExpire) |=> $stable(rangeCode))
		else $error("range pin applied while autorange selected");

	a_trigger_start: assert property (@(posedge sys_clk) disable iff (rst)
		(trigFall && stateQ == ENC_IDLE) |=> s_encode_start ##1 s_encode_busy)
		else $error("falling trigger did not start encode");

	a_freeze_hold: assert property (@(posedge sys_clk) disable iff (rst)
		(frozen && timerExpire) |=> $stable(displayValue))
		else $error("display updated while frozen");

	a_done_timing: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(conversionDone) |-> (sinceStartQ == DONE_AT))
		else $error("conversion done at wrong time");

	a_done_stays: assert property (@(posedge sys_clk) disable iff (rst)
		(conversionDone && !trigFall) |=> conversionDone)
		else $error("conversion done dropped without trigger");

endmodule : remote_range_control_port

/* verification/cmd_controller_model.sv */
// model of the external ttl command controller driving the programming pins
`timescale 1ns/100ps
module cmd_controller_model
(
	input  wire logic       lockReq,   // request panel lockout
	input  wire logic       logReq,    // request log display
	input  wire logic       autoReq,   // request autoranging
	input  wire logic       freezeReq, // request display hold
	input  wire logic       trigReq,   // high pulls the trigger line low
	input  wire logic       badRanges, // fault: pass range requests raw
	input  wire logic [6:0] rangeReq,  // wanted ranges, one bit each
	output logic            lockN,     // lockout pin
	output logic            logN,      // log display pin
	output logic            autoN,     // autorange pin
	output logic            freezeN,   // freeze pin
	output logic            trigN,     // trigger pin
	output logic      [6:0] rangeN     // range pins
);
	// a released line sits at the pulled-up high level
	always_comb
	begin
		lockN   = !lockReq;
		logN    = !logReq;
		autoN   = !autoReq;
		freezeN = !freezeReq;
		trigN   = !trigReq;
		rangeN  = 7'h7f;
		if (badRanges)
			rangeN = ~rangeReq;
		else if (lockReq && !autoReq)
			rangeN = ~(rangeReq & (~rangeReq + 7'h01));
	end
endmodule : cmd_controller_model

/* verification/remote_range_control_port_tb_top.sv */
// self-checking bench for the remote range control port
`timescale 1ns/100ps
module remote_range_control_port_tb_top;
	import range_port_pkg::*;
	logic               sys_clk = 1'b0;
	logic               rst = 1'b1;
	logic [ADDR_W-1:0]  address = 4'h0;
	logic               read = 1'b0;
	logic               write = 1'b0;
	logic [DATA_W-1:0]  writedata = 32'h0, readdata, rdata;
	logic               waitrequest;
	logic               lockReq = 1'b0, logReq = 1'b0, autoReq = 1'b0;
	logic               freezeReq = 1'b0, trigReq = 1'b0, badRanges = 1'b0;
	logic               overIn = 1'b0, underIn = 1'b0;
	logic [6:0]         rangeReq = 7'h00, rangeN;
	logic               lockN, logN, autoN, freezeN, trigN;
	logic [MEAS_W-1:0]  measIn = 16'h0000, displayValue;
	logic               convertStart, logMode, autoMode, conversionDone;
	logic [RANGE_W-1:0] rangeCode;
	int                 nErrors = 0, compares = 0, cycles = 0, lat;

	always #12.5 sys_clk = ~sys_clk;

	remote_range_control_port dut
	(
		.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .frontPanelLockoutN(lockN),
		.logDisplaySelectN(logN), .autorangeSelectN(autoN),
		.rangeSelectN(rangeN), .displayFreezeN(freezeN),
		.conversionTriggerN(trigN), .measIn(measIn), .overrangeIn(overIn),
		.underrangeIn(underIn), .convertStart(convertStart),
		.rangeCode(rangeCode), .logMode(logMode), .autoMode(autoMode),
		.displayValue(displayValue), .conversionDone(conversionDone)
	);

	cmd_controller_model partner
	(
		.lockReq(lockReq), .logReq(logReq), .autoReq(autoReq),
		.freezeReq(freezeReq), .trigReq(trigReq), .badRanges(badRanges),
		.rangeReq(rangeReq), .lockN(lockN), .logN(logN), .autoN(autoN),
		.freezeN(freezeN), .trigN(trigN), .rangeN(rangeN)
	);

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, nErrors);
		if (nErrors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// well above the three encode cycles plus bus traffic
	always @(posedge sys_clk)
	begin
		cycles = cycles + 1;
		if (cycles == 30000)
		begin
			nErrors++;
			end_of_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// pins pass a filter, so give them time before looking at outputs
	task automatic settle();
		repeat (8) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		address   <= a;
		writedata <= wd;
		write     <= wr;
		read      <= !wr;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 50);
		rdata = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		chk("bus answer", 32'(n < 50), 32'h1);
	endtask : bus

	// trigger fall; optional second fall mid-cycle must be ignored
	task automatic encode(input logic [MEAS_W-1:0] m, input logic again);
		int n;
		@(posedge sys_clk);
		trigReq <= 1'b0;
		measIn  <= m;
		settle();
		@(posedge sys_clk);
		trigReq <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		while (convertStart !== 1'b1 && n < 20);
		lat = cycles;
		chk("start seen", 32'(n < 20), 32'h1);
		chk("done low", 32'(conversionDone), 32'h0);
		if (again)
		begin
			@(posedge sys_clk);
			trigReq <= 1'b0;
			settle();
			@(posedge sys_clk);
			trigReq <= 1'b1;
		end
		do
		begin
			@(posedge sys_clk);
			#1;
		end
		while (conversionDone !== 1'b1 && cycles - lat < 5000);
		// start pulse to timer is one edge, expiry to done another
		chk("encode length", cycles - lat, ENCODE_CYCLES + 2);
	endtask : encode

	task automatic test_reset();
		settle();
		chk("rangeCode", 32'(rangeCode), 32'h0);
		chk("modes", {30'h0, logMode, autoMode}, 32'h0);
		chk("done", 32'(conversionDone), 32'h0);
		chk("display", 32'(displayValue), 32'h0);
		bus(1'b0, CTRL_ADDR, 32'h0);
		chk("ctrl", rdata, CTRL_RESET);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", rdata, 32'h0);
		$display("test_reset done");
	endtask : test_reset

	task automatic test_panel();
		bus(1'b1, CTRL_ADDR, 32'h0000_0003);
		@(posedge sys_clk);
		logReq <= 1'b1;
		settle();
		chk("rangeCode", 32'(rangeCode), 32'h3);
		chk("logMode", 32'(logMode), 32'h0);
		@(posedge sys_clk);
		lockReq  <= 1'b1;
		rangeReq <= 7'h20;
		settle();
		chk("rangeCode", 32'(rangeCode), 32'h5);
		chk("logMode", 32'(logMode), 32'h1);
		bus(1'b1, CTRL_ADDR, 32'h0000_0031);
		settle();
		chk("rangeCode", 32'(rangeCode), 32'h5);
		chk("autoMode", 32'(autoMode), 32'h0);
		bus(1'b0, CTRL_ADDR, 32'h0);
		chk("ctrl", rdata, 32'h0000_0031);
		$display("test_panel done");
	endtask : test_panel

	task automatic test_ranges();
		for (int i = 0; i < NUM_RANGES; i++)
		begin
			@(posedge sys_clk);
			rangeReq <= 7'(1 << i);
			settle();
			chk("rangeCode", 32'(rangeCode), 32'(i));
		end
		@(posedge sys_clk);
		autoReq   <= 1'b1;
		badRanges <= 1'b1;
		rangeReq  <= 7'h02;
		settle();
		chk("rangeCode", 32'(rangeCode), 32'h6);
		chk("autoMode", 32'(autoMode), 32'h1);
		@(posedge sys_clk);
		{lockReq, logReq, autoReq, badRanges} <= 4'h0;
		settle();
		$display("test_ranges done");
	endtask : test_ranges

	task automatic test_encode();
		// panel autorange is on at range 6: an underrange result steps down
		@(posedge sys_clk);
		underIn <= 1'b1;
		encode(16'h1234, 1'b1);
		chk("display", 32'(displayValue), 32'h1234);
		chk("auto step down", 32'(rangeCode), 32'h5);
		bus(1'b0, STATUS_ADDR, 32'h0);
		chk("status", rdata, 32'h0000_0a35);
		@(posedge sys_clk);
		underIn <= 1'b0;
		bus(1'b0, COUNT_ADDR, 32'h0);
		chk("count", rdata, 32'h1);
		$display("test_encode done");
	endtask : test_encode

	task automatic test_freeze();
		@(posedge sys_clk);
		freezeReq <= 1'b1;
		overIn    <= 1'b1;
		settle();
		encode(16'h5678, 1'b0);
		chk("display", 32'(displayValue), 32'h1234);
		chk("auto step up", 32'(rangeCode), 32'h6);
		@(posedge sys_clk);
		freezeReq <= 1'b0;
		overIn    <= 1'b0;
		settle();
		encode(16'h9abc, 1'b0);
		chk("display", 32'(displayValue), 32'h9abc);
		bus(1'b0, DISPLAY_ADDR, 32'h0);
		chk("display reg", rdata, 32'h0000_9abc);
		bus(1'b0, COUNT_ADDR, 32'h0);
		chk("count", rdata, 32'h3);
		$display("test_freeze done");
	endtask : test_freeze

	initial
	begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		test_reset();
		test_panel();
		test_ranges();
		test_encode();
		test_freeze();
		end_of_test();
	end
endmodule : remote_range_control_port_tb_top
